/* design/swd_sense_wire_diag.v */
// Sense-wire open diagnostic: config overrides, result compare and alert flags
// What this block does
// - Either sense-wire open mode forces bipolar conversion for near-zero voltages.
// - Diagnostic closes only nonadjacent switches, odd or even set by mode.
// - Alternate-path select is forced to one throughout the diagnostic scan.
// - Every measured result is compared with both high and low limits.
// - A result outside the window sets that channel's alert flag bit.
// - Switch enable is overridden with 1555h odd or 2AAAh even.
// - Override masks bus-bar positions and positions above the top setting.
// - Scan clears current/block, auxiliary enables and both diagnostic selects.
// - Cell measure enable equals overridden switch enable and not bus-bar flag.
// - Oversample rate is forced to zero, one sample per channel.
// - Overrides apply only while scanning; user settings return at the end.
// - Odd diagnostic measures odd cells only; even cells stay unmeasured.
// - Low-limit violations are reported; unmeasured channels raise no alert.
// - Results are limited to 2.5 V before the limit comparisons.
// - Bus-bar positions are excluded from switch closure and measurement.
// - At scan end the summary bit becomes the OR of all flags.
// - Over/undervoltage and mismatch alerts are not updated in diagnostic scans.
//
// The Avalon-MM register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "swd_consts.vh"
module swd_sense_wire_diag (
  input  wire        clk_in,
  input  wire        sys_rst_in,
  input  wire [5:0]  avm_address_in,
  input  wire        avm_read_in,
  input  wire        avm_write_in,
  input  wire [31:0] avm_writedata_in,
  output reg  [31:0] avm_readdata_out,
  output reg         avm_waitrequest_out,
  input  wire        meas_valid_in,
  input  wire [3:0]  meas_channel_in,
  input  wire [13:0] meas_data_in,
  input  wire        scan_done_in,
  output reg         scan_request_out,
  output reg         scan_busy_out,
  output reg  [13:0] balance_switch_enable_out,
  output reg  [15:0] cell_measure_enable_out,
  output reg  [3:0]  aux_measure_enable_out,
  output reg  [7:0]  diagnostic_select_out,
  output reg         alternate_path_select_out,
  output reg  [2:0]  oversample_rate_out,
  output reg         bipolar_mode_out,
  output reg         normal_alert_update_out,
  output reg  [13:0] switch_alert_flags_out,
  output reg         switch_alert_summary_out
);

  localparam [1:0] ST_IDLE    = 2'h0;
  localparam [1:0] ST_ACTIVE  = 2'h1;
  localparam [1:0] ST_COMPARE = 2'h2;
  localparam [1:0] ST_FINISH  = 2'h3;

  // User-programmed configuration
  reg  [2:0]  scan_config_select_q;
  reg  [3:0]  top_position_setting_q;
  reg         user_alt_path_q;
  reg         user_bipolar_q;
  reg  [2:0]  user_oversample_q;
  reg  [13:0] user_balance_q;
  reg  [15:0] user_measure_q;
  reg  [3:0]  user_aux_q;
  reg  [7:0]  user_diag_sel_q;
  reg  [13:0] busbar_position_flag_q;
  reg  [13:0] switch_low_limit_q;
  reg  [13:0] switch_high_limit_q;

  // Scan state
  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg         diag_q;
  reg         odd_q;
  reg  [3:0]  cmp_addr_q;
  reg  [3:0]  cmp_chan_q;
  reg         cmp_valid_q;
  reg  [13:0] new_flags_q;
  reg  [13:0] diag_switch_q;

  // Bus handshake and result-store wires
  wire        bus_req;
  wire        bus_take;
  wire        wr_take;
  wire        start_req;
  wire [13:0] rd_data;
  wire [13:0] clamped;
  wire        mem_we;

  // Positions at or below the top setting
  function [13:0] swd_top_mask;
    input [3:0] top;
    integer i;
    begin
      swd_top_mask = 14'h0000;
      for (i = 0; i < `SWD_CHANNELS; i = i + 1)
      begin
        if (i < top)
        begin
          swd_top_mask[i] = 1'b1;
        end
      end
    end
  endfunction

  // Diagnostic switch pattern after masking
  function [13:0] swd_diag_switches;
    input        odd;
    input [13:0] busbar;
    input [3:0]  top;
    begin
      swd_diag_switches = (odd ? `SWD_ODD_PATTERN : `SWD_EVEN_PATTERN) & ~busbar &
                          swd_top_mask(top);
    end
  endfunction

  // Limit results at the 2.5 V code
  function [13:0] swd_clamp;
    input [13:0] data;
    begin
      swd_clamp = (data > `SWD_RESULT_MAX) ? `SWD_RESULT_MAX : data;
    end
  endfunction

  // Request held until waitrequest drops; one wait cycle each access
  assign bus_req   = avm_read_in | avm_write_in;
  assign bus_take  = bus_req & ~avm_waitrequest_out;
  assign wr_take   = avm_write_in & ~avm_waitrequest_out;
  assign start_req = wr_take & (avm_address_in == `SWD_ADDR_SCAN_CONTROL) &
                     avm_writedata_in[`SWD_CTRL_START_BIT];

  // Results captured only while a scan runs
  assign mem_we  = (state_q == ST_ACTIVE) & meas_valid_in &
                   (meas_channel_in <= `SWD_LAST_CHANNEL);
  assign clamped = swd_clamp(rd_data);

  swd_result_mem u_results (
    .clk_in      (clk_in),
    .wr_en_in    (mem_we),
    .wr_addr_in  (meas_channel_in),
    .wr_data_in  (meas_data_in),
    .rd_addr_in  (cmp_addr_q),
    .rd_data_out (rd_data)
  );

  // Waitrequest and read data, both registered
  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      avm_waitrequest_out <= 1'b1;
      avm_readdata_out    <= 32'h00000000;
    end
    else
    begin
      avm_waitrequest_out <= ~(bus_req & avm_waitrequest_out);
      if (avm_read_in & avm_waitrequest_out)
      begin
        case (avm_address_in)
          `SWD_ADDR_SCAN_CONFIG:
            avm_readdata_out <= {24'h000000, top_position_setting_q, 1'b0,
                                 scan_config_select_q};
          `SWD_ADDR_SCAN_CONTROL:
            avm_readdata_out <= {23'h000000, scan_busy_out, 1'b0, user_oversample_q, 1'b0,
                                 user_bipolar_q, user_alt_path_q, 1'b0};
          `SWD_ADDR_BALANCE:
            avm_readdata_out <= {18'h00000, user_balance_q};
          `SWD_ADDR_CELL_MEASURE:
            avm_readdata_out <= {16'h0000, user_measure_q};
          `SWD_ADDR_AUX_DIAG:
            avm_readdata_out <= {20'h00000, user_diag_sel_q, user_aux_q};
          `SWD_ADDR_BUSBAR:
            avm_readdata_out <= {18'h00000, busbar_position_flag_q};
          `SWD_ADDR_LIMITS:
            avm_readdata_out <= {2'h0, switch_high_limit_q, 2'h0, switch_low_limit_q};
          `SWD_ADDR_ALERTS:
            avm_readdata_out <= {15'h0000, switch_alert_summary_out, 2'h0,
                                 switch_alert_flags_out};
          default:
            avm_readdata_out <= 32'h00000000;
        endcase
      end
    end
  end

  // Configuration registers; unmapped writes are dropped
  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      scan_config_select_q   <= 3'h0;
      top_position_setting_q <= `SWD_RST_TOP;
      user_alt_path_q        <= 1'b0;
      user_bipolar_q         <= 1'b0;
      user_oversample_q      <= 3'h0;
      user_balance_q         <= 14'h0000;
      user_measure_q         <= 16'h0000;
      user_aux_q             <= 4'h0;
      user_diag_sel_q        <= 8'h00;
      busbar_position_flag_q <= 14'h0000;
      switch_low_limit_q     <= `SWD_RST_LOW_LIMIT;
      switch_high_limit_q    <= `SWD_RST_HIGH_LIMIT;
    end
    else if (wr_take)
    begin
      case (avm_address_in)
        `SWD_ADDR_SCAN_CONFIG:
        begin
          scan_config_select_q   <= avm_writedata_in[2:0];
          top_position_setting_q <= avm_writedata_in[7:4];
        end
        `SWD_ADDR_SCAN_CONTROL:
        begin
          user_alt_path_q   <= avm_writedata_in[`SWD_CTRL_ALT_BIT];
          user_bipolar_q    <= avm_writedata_in[`SWD_CTRL_BIPOLAR_BIT];
          user_oversample_q <= avm_writedata_in[6:4];
        end
        `SWD_ADDR_BALANCE:      user_balance_q <= avm_writedata_in[13:0];
        `SWD_ADDR_CELL_MEASURE: user_measure_q <= avm_writedata_in[15:0];
        `SWD_ADDR_AUX_DIAG:
        begin
          user_aux_q      <= avm_writedata_in[3:0];
          user_diag_sel_q <= avm_writedata_in[11:4];
        end
        `SWD_ADDR_BUSBAR:       busbar_position_flag_q <= avm_writedata_in[13:0];
        `SWD_ADDR_LIMITS:
        begin
          switch_low_limit_q  <= avm_writedata_in[13:0];
          switch_high_limit_q <= avm_writedata_in[29:16];
        end
        default:
        begin
          scan_config_select_q <= scan_config_select_q;
        end
      endcase
    end
  end

  // Next scan state
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
        if (start_req)
        begin
          state_d = ST_ACTIVE;
        end
      ST_ACTIVE:
        if (scan_done_in)
        begin
          state_d = diag_q ? ST_COMPARE : ST_FINISH;
        end
      ST_COMPARE:
        if (cmp_valid_q & (cmp_chan_q == `SWD_LAST_CHANNEL))
        begin
          state_d = ST_FINISH;
        end
      ST_FINISH:
        state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  // Scan sequencing and per-channel window compare
  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      state_q          <= ST_IDLE;
      diag_q           <= 1'b0;
      odd_q            <= 1'b0;
      diag_switch_q    <= 14'h0000;
      cmp_addr_q       <= 4'h0;
      cmp_chan_q       <= 4'h0;
      cmp_valid_q      <= 1'b0;
      new_flags_q      <= 14'h0000;
      scan_request_out <= 1'b0;
    end
    else
    begin
      state_q          <= state_d;
      scan_request_out <= (state_q == ST_IDLE) & start_req;
      if ((state_q == ST_IDLE) & start_req)
      begin
        diag_q        <= (scan_config_select_q == `SWD_MODE_ODD) |
                         (scan_config_select_q == `SWD_MODE_EVEN);
        odd_q         <= (scan_config_select_q == `SWD_MODE_ODD);
        diag_switch_q <= swd_diag_switches(scan_config_select_q == `SWD_MODE_ODD,
                                           busbar_position_flag_q, top_position_setting_q);
        new_flags_q   <= 14'h0000;
        cmp_addr_q    <= 4'h0;
        cmp_valid_q   <= 1'b0;
      end
      // Read address runs one cycle ahead of the data
      if (state_q == ST_COMPARE)
      begin
        cmp_chan_q  <= cmp_addr_q;
        cmp_valid_q <= 1'b1;
        if (cmp_addr_q != `SWD_LAST_CHANNEL)
        begin
          cmp_addr_q <= cmp_addr_q + 4'h1;
        end
        if (cmp_valid_q)
        begin
          new_flags_q[cmp_chan_q] <= diag_switch_q[cmp_chan_q] &
                                     ~busbar_position_flag_q[cmp_chan_q] &
                                     ((clamped < switch_low_limit_q) |
                                      (clamped > switch_high_limit_q));
        end
      end
    end
  end

  // Alert flags: end-of-scan update wins over a same-cycle software clear
  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      switch_alert_flags_out   <= 14'h0000;
      switch_alert_summary_out <= 1'b0;
    end
    else if ((state_q == ST_FINISH) & diag_q)
    begin
      switch_alert_flags_out   <= new_flags_q;
      switch_alert_summary_out <= |new_flags_q;
    end
    else if (wr_take & (avm_address_in == `SWD_ADDR_ALERTS))
    begin
      switch_alert_flags_out   <= switch_alert_flags_out & avm_writedata_in[13:0];
      switch_alert_summary_out <= switch_alert_summary_out &
                                  avm_writedata_in[`SWD_SUMMARY_BIT];
    end
  end

  // Effective configuration toward the acquisition path, registered
  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      scan_busy_out             <= 1'b0;
      balance_switch_enable_out <= 14'h0000;
      cell_measure_enable_out   <= 16'h0000;
      aux_measure_enable_out    <= 4'h0;
      diagnostic_select_out     <= 8'h00;
      alternate_path_select_out <= 1'b0;
      oversample_rate_out       <= 3'h0;
      bipolar_mode_out          <= 1'b0;
      normal_alert_update_out   <= 1'b0;
    end
    else if ((state_d == ST_ACTIVE) & ((state_q == ST_ACTIVE) ? diag_q :
             ((scan_config_select_q == `SWD_MODE_ODD) |
              (scan_config_select_q == `SWD_MODE_EVEN))))
    begin
      scan_busy_out             <= 1'b1;
      balance_switch_enable_out <= (state_q == ST_ACTIVE) ? diag_switch_q :
        swd_diag_switches(scan_config_select_q == `SWD_MODE_ODD,
                          busbar_position_flag_q, top_position_setting_q);
      cell_measure_enable_out   <= {`SWD_FORCE_CSA_BLK, ((state_q == ST_ACTIVE) ?
        diag_switch_q : swd_diag_switches(scan_config_select_q == `SWD_MODE_ODD,
        busbar_position_flag_q, top_position_setting_q)) & ~busbar_position_flag_q};
      aux_measure_enable_out    <= `SWD_FORCE_AUX;
      diagnostic_select_out     <= `SWD_FORCE_DIAGSEL;
      alternate_path_select_out <= `SWD_FORCE_ALT_PATH;
      oversample_rate_out       <= `SWD_FORCE_OVERSAMPLE;
      bipolar_mode_out          <= 1'b1;
      normal_alert_update_out   <= 1'b0;
    end
    else
    begin
      scan_busy_out             <= (state_d != ST_IDLE);
      balance_switch_enable_out <= user_balance_q;
      cell_measure_enable_out   <= user_measure_q;
      aux_measure_enable_out    <= user_aux_q;
      diagnostic_select_out     <= user_diag_sel_q;
      alternate_path_select_out <= user_alt_path_q;
      oversample_rate_out       <= user_oversample_q;
      bipolar_mode_out          <= user_bipolar_q;
      normal_alert_update_out   <= ~((state_d != ST_IDLE) & diag_q &
                                     (state_q != ST_IDLE));
    end
  end

endmodule

/* design/swd_consts.vh */
// Register offsets, field positions, reset values and codes for the sense-wire diagnostic
`ifndef SWD_CONSTS_VH
`define SWD_CONSTS_VH

// Register byte offsets on the Avalon-MM slave
`define SWD_ADDR_SCAN_CONFIG   6'h00
`define SWD_ADDR_SCAN_CONTROL  6'h04
`define SWD_ADDR_BALANCE       6'h08
`define SWD_ADDR_CELL_MEASURE  6'h0c
`define SWD_ADDR_AUX_DIAG      6'h10
`define SWD_ADDR_BUSBAR        6'h14
`define SWD_ADDR_LIMITS        6'h18
`define SWD_ADDR_ALERTS        6'h1c

// Scan configuration field codes
`define SWD_MODE_ODD           3'h6
`define SWD_MODE_EVEN          3'h7

// Switch enable patterns forced in the two diagnostics
`define SWD_ODD_PATTERN        14'h1555
`define SWD_EVEN_PATTERN       14'h2aaa

// Forced values during a diagnostic scan
`define SWD_FORCE_CSA_BLK      2'h0
`define SWD_FORCE_AUX          4'h0
`define SWD_FORCE_DIAGSEL      8'h00
`define SWD_FORCE_OVERSAMPLE   3'h0
`define SWD_FORCE_ALT_PATH     1'b1

// Result code for 2.5 V; results above are limited to it
`define SWD_RESULT_MAX         14'h1fff

// Field positions
`define SWD_CTRL_START_BIT     0
`define SWD_CTRL_ALT_BIT       1
`define SWD_CTRL_BIPOLAR_BIT   2
`define SWD_CTRL_BUSY_BIT      8
`define SWD_SUMMARY_BIT        16

// Reset values
`define SWD_RST_TOP            4'he
`define SWD_RST_HIGH_LIMIT     14'h1fff
`define SWD_RST_LOW_LIMIT      14'h0000

// Channel count and last channel index
`define SWD_CHANNELS           14
`define SWD_LAST_CHANNEL       4'hd

`endif

/* design/swd_result_mem.v */
// Result store: 16 words of 14 bits, registered read port
`timescale 1ns/1ps
module swd_result_mem (
  input  wire        clk_in,
  input  wire        wr_en_in,
  input  wire [3:0]  wr_addr_in,
  input  wire [13:0] wr_data_in,
  input  wire [3:0]  rd_addr_in,
  output reg  [13:0] rd_data_out
);

  reg [13:0] mem_q [0:15];

  // Write and registered read; contents need no reset
  always @(posedge clk_in)
  begin
    if (wr_en_in)
    begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem_q[rd_addr_in];
  end

endmodule

/* testbench/swd_sense_wire_diag_assertions.sv */
// Port-level checks for the sense-wire open diagnostic
`timescale 1ns/1ps
`include "swd_consts.vh"
module swd_sense_wire_diag_assertions (
  input wire        clk_in,
  input wire        sys_rst_in,
  input wire        avm_read_in,
  input wire        avm_write_in,
  input wire        avm_waitrequest_out,
  input wire        scan_done_in,
  input wire        scan_request_out,
  input wire        scan_busy_out,
  input wire [13:0] balance_switch_enable_out,
  input wire [15:0] cell_measure_enable_out,
  input wire [3:0]  aux_measure_enable_out,
  input wire [7:0]  diagnostic_select_out,
  input wire        alternate_path_select_out,
  input wire [2:0]  oversample_rate_out,
  input wire        bipolar_mode_out,
  input wire        normal_alert_update_out,
  input wire [13:0] switch_alert_flags_out,
  input wire        switch_alert_summary_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  reg        in_meas_q;
  reg        diag_run_q;
  reg [13:0] meas_set_q;
  // Measuring window and the cell set of the latest scan
  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      in_meas_q <= 1'b0;
      diag_run_q <= 1'b0;
      meas_set_q <= 14'h0;
    end
    else if (scan_request_out)
    begin
      in_meas_q <= 1'b1;
      diag_run_q <= !normal_alert_update_out;
      meas_set_q <= cell_measure_enable_out[13:0];
    end
    else if (scan_done_in)
      in_meas_q <= 1'b0;
  end
  sequence s_diag_start;
    scan_request_out && !normal_alert_update_out;
  endsequence
  sequence s_scan_end;
    $fell(scan_busy_out);
  endsequence
  AST_ALT_BIPOLAR: assert property (s_diag_start |->
    alternate_path_select_out && bipolar_mode_out) else $error("diag path not forced");
  AST_CLEARED: assert property (s_diag_start |-> oversample_rate_out == 3'h0 &&
    aux_measure_enable_out == 4'h0 && diagnostic_select_out == 8'h00)
    else $error("diag enables not cleared");
  AST_MEAS_SUBSET: assert property (s_diag_start |->
    (cell_measure_enable_out & ~{2'b11, balance_switch_enable_out}) == 16'h0)
    else $error("measured cell without closed switch");
  AST_NONADJ: assert property (s_diag_start |->
    (balance_switch_enable_out & ~`SWD_ODD_PATTERN) == 14'h0 ||
    (balance_switch_enable_out & ~`SWD_EVEN_PATTERN) == 14'h0) else $error("adjacent switches");
  AST_HOLD: assert property (in_meas_q && $past(in_meas_q) |->
    $stable(balance_switch_enable_out) && $stable(cell_measure_enable_out))
    else $error("overrides moved mid-scan");
  AST_NORMAL_LOW: assert property (in_meas_q && diag_run_q |->
    !normal_alert_update_out) else $error("normal alerts enabled in diag");
  AST_SUMMARY: assert property (s_scan_end |->
    switch_alert_summary_out == |switch_alert_flags_out) else $error("summary mismatch");
  AST_NO_UNMEASURED: assert property (s_scan_end and diag_run_q |->
    (switch_alert_flags_out & ~meas_set_q) == 14'h0) else $error("unmeasured flag set");
  AST_FLAG_HOLD: assert property (!scan_busy_out && !avm_write_in |=>
    $stable(switch_alert_flags_out)) else $error("flags moved while idle");
  AST_SCAN_END: assert property (scan_done_in && in_meas_q |->
    ##[1:60] !scan_busy_out ##[0:4] normal_alert_update_out) else $error("scan never ended");
  AST_WAIT_ONE: assert property ((avm_read_in || avm_write_in) && avm_waitrequest_out |=>
    !avm_waitrequest_out ##1 avm_waitrequest_out) else $error("bus answer timing");
endmodule

/* testbench/swd_acq_model.sv */
// Acquisition stand-in: one result per enabled cell, then end of scan
`timescale 1ns/1ps
module swd_acq_model (
  input  wire         clk_in,
  input  wire         scan_request_in,
  input  wire [15:0]  measure_en_in,
  input  wire [195:0] cell_data_in,
  input  wire [3:0]   gap_in,
  output reg          meas_valid_out,
  output reg  [3:0]   meas_channel_out,
  output reg  [13:0]  meas_data_out,
  output reg          scan_done_out
);
  integer    ch;
  reg [15:0] en;
  initial
  begin
    meas_valid_out = 1'b0;
    meas_channel_out = 4'h0;
    meas_data_out = 14'h2aaa;
    scan_done_out = 1'b0;
  end
  // Data lines churn between results so stale values never look valid
  always
  begin
    @(posedge clk_in);
    if (scan_request_in === 1'b1)
    begin
      en = measure_en_in;
      for (ch = 0; ch < 14; ch = ch + 1)
      begin
        repeat (gap_in)
        begin
          @(posedge clk_in);
          meas_valid_out <= 1'b0;
          meas_data_out <= ~meas_data_out;
        end
        @(posedge clk_in);
        meas_valid_out <= en[ch];
        meas_channel_out <= ch[3:0];
        meas_data_out <= en[ch] ? cell_data_in[ch*14 +: 14] : ~meas_data_out;
      end
      @(posedge clk_in);
      meas_valid_out <= 1'b0;
      scan_done_out <= 1'b1;
      @(posedge clk_in);
      scan_done_out <= 1'b0;
    end
  end
endmodule

/* testbench/swd_sense_wire_diag_tb.sv */
// Self-checking bench for the sense-wire open diagnostic
`timescale 1ns/1ps
`include "swd_consts.vh"
module swd_sense_wire_diag_tb;
  reg          clk_in = 1'b0;
  reg          sys_rst_in = 1'b1;
  reg  [5:0]   avm_address_in = 6'h00;
  reg          avm_read_in = 1'b0;
  reg          avm_write_in = 1'b0;
  reg  [31:0]  avm_writedata_in = 32'h0;
  reg  [195:0] cdata = 196'h0;
  reg  [3:0]   gap = 4'h0;
  reg  [13:0]  flg = 14'h0;
  integer      fail_count = 0;
  integer      checks_done = 0;
  wire [31:0]  avm_readdata_out;
  wire         avm_waitrequest_out, meas_valid_in, scan_done_in;
  wire         scan_request_out, scan_busy_out, alternate_path_select_out;
  wire         bipolar_mode_out, normal_alert_update_out, switch_alert_summary_out;
  wire [3:0]   meas_channel_in, aux_measure_enable_out;
  wire [13:0]  meas_data_in, balance_switch_enable_out, switch_alert_flags_out;
  wire [15:0]  cell_measure_enable_out;
  wire [7:0]   diagnostic_select_out;
  wire [2:0]   oversample_rate_out;
  swd_sense_wire_diag dut (.clk_in, .sys_rst_in, .avm_address_in, .avm_read_in,
    .avm_write_in, .avm_writedata_in, .avm_readdata_out, .avm_waitrequest_out,
    .meas_valid_in, .meas_channel_in, .meas_data_in, .scan_done_in, .scan_request_out,
    .scan_busy_out, .balance_switch_enable_out, .cell_measure_enable_out,
    .aux_measure_enable_out, .diagnostic_select_out, .alternate_path_select_out,
    .oversample_rate_out, .bipolar_mode_out, .normal_alert_update_out,
    .switch_alert_flags_out, .switch_alert_summary_out);
  swd_acq_model u_acq (.clk_in(clk_in), .scan_request_in(scan_request_out),
    .measure_en_in(cell_measure_enable_out), .cell_data_in(cdata), .gap_in(gap),
    .meas_valid_out(meas_valid_in), .meas_channel_out(meas_channel_in),
    .meas_data_out(meas_data_in), .scan_done_out(scan_done_in));
  // Free-running 10 MHz clock
  always #50 clk_in = ~clk_in;
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
  begin
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      fail_count = fail_count + 1;
      $display("[FAIL] %0s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask
  // One bus access; the request is held until waitrequest is seen low
  task bus(input wr, input [5:0] a, input [31:0] d, output [31:0] q);
  begin
    @(posedge clk_in);
    avm_address_in <= a;
    avm_writedata_in <= d;
    avm_write_in <= wr;
    avm_read_in <= !wr;
    @(posedge clk_in);
    while (avm_waitrequest_out !== 1'b0)
      @(posedge clk_in);
    q = avm_readdata_out;
    avm_write_in <= 1'b0;
    avm_read_in <= 1'b0;
  end
  endtask
  task wr(input [5:0] a, input [31:0] d);
    reg [31:0] q;
  begin
    bus(1'b1, a, d, q);
  end
  endtask
  task complete_run;
  begin
    if (fail_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  // Generic scan: program, settle, start, then judge overrides, flags and restore
  task t_scan(input [2:0] mode, input [13:0] bb, input [3:0] top, input [13:0] hi, input chg);
    reg        dg;
    reg [13:0] sw;
    reg [13:0] r;
    reg [31:0] q;
    integer    k;
  begin
    dg = (mode == `SWD_MODE_ODD) || (mode == `SWD_MODE_EVEN);
    sw = (mode[0] ? `SWD_EVEN_PATTERN : `SWD_ODD_PATTERN) & ~bb & ((14'h1 << top) - 14'h1);
    for (k = 0; k < 14 && dg; k = k + 1)
    begin
      r = cdata[k*14 +: 14];
      if (r > `SWD_RESULT_MAX)
        r = `SWD_RESULT_MAX;
      flg[k] = sw[k] && (r < 14'h0100 || r > hi);
    end
    if (!dg)
      sw = 14'h0003;
    wr(`SWD_ADDR_BUSBAR, {18'h0, bb});
    wr(`SWD_ADDR_LIMITS, {2'h0, hi, 16'h0100});
    wr(`SWD_ADDR_SCAN_CONFIG, {24'h0, top, 1'b0, mode});
    repeat (1000) @(posedge clk_in);
    wr(`SWD_ADDR_SCAN_CONTROL, 32'h31);
    for (k = 0; k < 20 && scan_request_out !== 1'b1; k = k + 1)
      @(negedge clk_in);
    chk("request", scan_request_out, 1);
    chk("switches", balance_switch_enable_out, sw);
    chk("measure", cell_measure_enable_out, dg ? {2'b00, sw & ~bb} : 16'hc00f);
    chk("altpath", alternate_path_select_out, dg);
    chk("bipolar", bipolar_mode_out, dg);
    chk("oversample", oversample_rate_out, dg ? 0 : 3);
    chk("auxdiag", {aux_measure_enable_out, diagnostic_select_out}, dg ? 0 : 12'h50a);
    chk("normupd", normal_alert_update_out, !dg);
    if (chg)
      wr(`SWD_ADDR_SCAN_CONFIG, {24'h0, top, 1'b0, mode ^ 3'h1});
    for (k = 0; k < 400 && scan_busy_out !== 1'b0; k = k + 1)
      @(negedge clk_in);
    chk("flags", switch_alert_flags_out, flg);
    chk("summary", switch_alert_summary_out, |flg);
    bus(1'b0, `SWD_ADDR_ALERTS, 32'h0, q);
    chk("alertreg", q, {15'h0, |flg, 2'h0, flg});
    for (k = 0; k < 10 && balance_switch_enable_out !== 14'h0003; k = k + 1)
      @(negedge clk_in);
    chk("restore", {balance_switch_enable_out, alternate_path_select_out, bipolar_mode_out,
      oversample_rate_out, normal_alert_update_out}, {14'h0003, 2'b00, 3'h3, 1'b1});
    chk("restoremeas", {cell_measure_enable_out, aux_measure_enable_out, diagnostic_select_out},
      {16'hc00f, 12'h50a});
  end
  endtask
  // Reset values, unmapped access, then user configuration
  task t_reset;
    reg [31:0] q;
  begin
    bus(1'b0, `SWD_ADDR_SCAN_CONFIG, 32'h0, q);
    chk("cfgreset", q, 32'he0);
    bus(1'b0, `SWD_ADDR_LIMITS, 32'h0, q);
    chk("limreset", q, 32'h1fff0000);
    wr(6'h20, 32'hffffffff);
    bus(1'b0, 6'h20, 32'h0, q);
    chk("unmapped", q, 0);
    wr(`SWD_ADDR_BALANCE, 32'h3);
    wr(`SWD_ADDR_CELL_MEASURE, 32'hc00f);
    wr(`SWD_ADDR_AUX_DIAG, 32'h0a5);
    wr(`SWD_ADDR_SCAN_CONTROL, 32'h30);
    bus(1'b0, `SWD_ADDR_SCAN_CONTROL, 32'h0, q);
    chk("ctrlread", q, 32'h30);
  end
  endtask
  // Odd run: low and high faults, idle even cell, mode rewritten mid-scan
  task t_odd_fault;
  begin
    cdata = {14{14'h0800}};
    cdata[2*14 +: 14] = 14'h0010;
    cdata[4*14 +: 14] = 14'h1900;
    cdata[1*14 +: 14] = 14'h0000;
    gap = 4'h3;
    t_scan(`SWD_MODE_ODD, 14'h0, 4'he, 14'h1800, 1'b1);
  end
  endtask
  // Even run with a bus bar, short stack and a clipped result, fast partner
  task t_even_busbar;
  begin
    cdata = {14{14'h0800}};
    cdata[3*14 +: 14] = 14'h0000;
    cdata[11*14 +: 14] = 14'h0000;
    cdata[5*14 +: 14] = 14'h3fff;
    cdata[7*14 +: 14] = 14'h0010;
    gap = 4'h0;
    t_scan(`SWD_MODE_EVEN, 14'h0008, 4'ha, 14'h1fff, 1'b0);
  end
  endtask
  // Ordinary scan with bad data must leave the flags alone
  task t_normal;
  begin
    cdata = 196'h0;
    t_scan(3'h0, 14'h0, 4'he, 14'h1800, 1'b0);
  end
  endtask
  task t_clear;
    reg [31:0] q;
  begin
    wr(`SWD_ADDR_ALERTS, 32'h0);
    bus(1'b0, `SWD_ADDR_ALERTS, 32'h0, q);
    chk("cleared", q, 0);
  end
  endtask
  initial
  begin
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    t_reset;
    t_odd_fault;
    t_even_busbar;
    t_normal;
    t_clear;
    complete_run;
  end
  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (40000) @(posedge clk_in);
    fail_count = fail_count + 1;
    complete_run;
  end
endmodule
bind swd_sense_wire_diag swd_sense_wire_diag_assertions u_chk (.clk_in, .sys_rst_in,
  .avm_read_in, .avm_write_in, .avm_waitrequest_out, .scan_done_in, .scan_request_out,
  .scan_busy_out, .balance_switch_enable_out, .cell_measure_enable_out,
  .aux_measure_enable_out, .diagnostic_select_out, .alternate_path_select_out,
  .oversample_rate_out, .bipolar_mode_out, .normal_alert_update_out,
  .switch_alert_flags_out, .switch_alert_summary_out);
